// ---- hw/lps_top.sv ----
// Operation
// [R1] - Port C bit one: columns 27-30
// [R2] - Port D bit two: columns 31-34
// [R3] - Bit three enables port pull-ups
// [R4] - Normal frame: 43/32 Hz by duty
// [R5] - Half frame: 21/16 Hz by duty
// [R6] - Stop turns pump and display off
// [R7] - Software clears shutdown after each wake
// [R8] - Non-solar: pad/power reset sets shutdown
// [R9] - Non-solar: pump on at clear, off on stop
// [R10] - Non-solar: setting shutdown blanks display only
// [R11] - Solar: power reset sets shutdown, all off
// [R12] - Solar: clear starts pump, then display
// [R13] - Solar: setting shutdown stops pump and display
// [R14] - Solar: pad reset changes nothing
// [R15] - Quarter duty: nibble bits 0-3 per plane
// [R16] - Third duty: bits 0-2, bit 3 unused
// [R17] - Watchdog reset: shutdown set, all off
// [R18] - Display off drives all lines low
// [R19] - Port data and column data kept apart
`timescale 1ns/1ps
module lps_top
#(
   parameter bit SOLAR_SUPPLY = 1'b0,
   parameter bit QUARTER_DUTY = 1'b1,
   parameter bit HALF_FRAME = 1'b0,
   parameter int PHASE_THIRD = lps_pkg::PHASE_CYC_THIRD,
   parameter int PHASE_QUARTER = lps_pkg::PHASE_CYC_QUARTER,
   parameter int HALF_THIRD = lps_pkg::HALF_CYC_THIRD,
   parameter int HALF_QUARTER = lps_pkg::HALF_CYC_QUARTER
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic padReset_n,
   input wire logic stopExec,
   input wire logic watchdogResetEvent,
   input wire lps_pkg::lps_port_t thirdIoPortIo,
   input wire lps_pkg::lps_port_t fourthIoPortIo,
   output lps_pkg::lps_port_t thirdIoPort,
   output lps_pkg::lps_port_t fourthIoPort,
   output logic [lps_pkg::DEDICATED_COLS-1:0] displayColumnLine,
   output logic [lps_pkg::NUM_PLANES-1:0] backplaneLine,
   output logic pumpOn,
   output logic displayOn,
   output logic portPullupEnable,
   output logic heavyLoadSelect
);
   import lps_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   lps_power_t pwr_reg;
   lps_power_t pwr_next;
   logic shutdown_reg;
   logic shutdown_next;
   logic [3:0] segExt_reg;
   logic [3:0] ram_reg [NUM_COLS];
   logic [NUM_COLS-1:0] column_reg;
   logic padSync1_reg;
   logic padSync2_reg;
   logic padActive;
   logic wrPend_reg;
   logic [11:0] wrIdx_reg;
   logic addrPhase;
   logic [11:0] busIdx;
   logic busMapped;
   logic ctrlWrite;
   logic writeClear;
   logic writeSet;
   logic [11:0] ramOff;
   logic [5:0] ramCol;
   logic ramWrite;
   logic [31:0] readMux;
   logic [1:0] planeIdx;
   logic phaseTick;

   // ---------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ---------------------------------------------------------------
   // Address phase decode
   assign addrPhase = hsel && htrans[1] && hready;
   assign busIdx = haddr[13:2];
   assign busMapped = (haddr[31:14] == 18'h0) && (haddr[1:0] == 2'b00);

   // Data phase write capture
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         wrPend_reg <= 1'b0;
         wrIdx_reg <= 12'h000;
      end
      else if (hready)
      begin
         wrPend_reg <= addrPhase && hwrite && busMapped;
         wrIdx_reg <= busIdx;
      end
   end

   // Read mux, unmapped reads as zero
   always_comb
   begin
      readMux = 32'h0000_0000;
      ramOff = busIdx - IDX_RAM_FIRST;
      if (!busMapped)
         readMux = 32'h0000_0000;
      else if (busIdx == IDX_DISP_CTRL)
      begin
         readMux[CTRL_SHUT_BIT] = shutdown_reg;
         readMux[CTRL_HEAVY_BIT] = heavyLoadSelect;
      end
      else if (busIdx == IDX_SEG_EXT)
         readMux[3:0] = {segExt_reg[3:1], 1'b0};
      else if (busIdx >= IDX_RAM_FIRST && busIdx <= IDX_RAM_LAST)
         readMux[3:0] = ram_reg[ramOff[5:0]];
   end

   // Registered answer, always OKAY
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (addrPhase && !hwrite)
            hrdata <= readMux;
      end
   end

   // ---------------------------------------------------------------
   // Software registers
   // ---------------------------------------------------------------
   assign ctrlWrite = wrPend_reg && (wrIdx_reg == IDX_DISP_CTRL);
   assign writeClear = ctrlWrite && !hwdata[CTRL_SHUT_BIT];
   assign writeSet = ctrlWrite && hwdata[CTRL_SHUT_BIT];
   assign ramCol = 6'(wrIdx_reg - IDX_RAM_FIRST);
   assign ramWrite = wrPend_reg && wrIdx_reg >= IDX_RAM_FIRST && wrIdx_reg <= IDX_RAM_LAST;

   // Segment extension and heavy load bits
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         segExt_reg <= SEGX_RESET;
         heavyLoadSelect <= HEAVY_RESET;
      end
      else
      begin
         if (wrPend_reg && wrIdx_reg == IDX_SEG_EXT)
            segExt_reg <= {hwdata[3:1], 1'b0};
         if (ctrlWrite)
            heavyLoadSelect <= hwdata[CTRL_HEAVY_BIT];
      end
   end

   // Pull-up control straight from bit three
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         portPullupEnable <= 1'b0;
      else
         portPullupEnable <= segExt_reg[SEGX_PULL_BIT]; // [R3]
   end

   // Display RAM, 34 nibbles
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NUM_COLS; i++)
            ram_reg[i] <= 4'h0;
      end
      else if (ramWrite)
         ram_reg[ramCol] <= hwdata[3:0];
   end

   // ---------------------------------------------------------------
   // Pad reset synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         padSync1_reg <= 1'b1;
         padSync2_reg <= 1'b1;
      end
      else
      begin
         padSync1_reg <= padReset_n;
         padSync2_reg <= padSync1_reg;
      end
   end
   assign padActive = !padSync2_reg;

   // ---------------------------------------------------------------
   // Pump and display power sequencing
   // ---------------------------------------------------------------
   // Next state by event priority: watchdog, stop, pad, write
   always_comb
   begin
      pwr_next = pwr_reg;
      shutdown_next = shutdown_reg;
      if (watchdogResetEvent)
      begin
         pwr_next = PWR_OFF; // [R17]
         shutdown_next = 1'b1;
      end
      else if (stopExec)
      begin
         pwr_next = PWR_OFF; // [R6] [R9]
         shutdown_next = 1'b1;
      end
      else if (padActive && !SOLAR_SUPPLY)
      begin
         shutdown_next = 1'b1; // [R8]
         pwr_next = (pwr_reg == PWR_OFF) ? PWR_OFF : PWR_PUMP;
      end
      else if (writeSet && !(padActive && SOLAR_SUPPLY))
      begin
         shutdown_next = 1'b1;
         if (SOLAR_SUPPLY)
            pwr_next = PWR_OFF; // [R13]
         else if (pwr_reg == PWR_ON)
            pwr_next = PWR_PUMP; // [R10]
      end
      else if (writeClear && !(padActive && SOLAR_SUPPLY))
      begin
         shutdown_next = 1'b0; // [R7]
         if (pwr_reg == PWR_OFF)
            pwr_next = PWR_PUMP; // [R9] [R12]
      end
      else if (!shutdown_reg && pwr_reg == PWR_PUMP)
         pwr_next = PWR_ON; // [R12]
   end

   // Power state and shutdown flag, power-on leaves all off
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pwr_reg <= PWR_OFF; // [R9] [R11]
         shutdown_reg <= 1'b1; // [R8] [R11]
      end
      else
      begin
         pwr_reg <= pwr_next; // [R14]
         shutdown_reg <= shutdown_next;
      end
   end
   assign pumpOn = pwr_reg[0];
   assign displayOn = pwr_reg[1];

   // ---------------------------------------------------------------
   // Frame timing and line drive
   // ---------------------------------------------------------------
   lps_frame_gen
   #(
      .PHASE_THIRD(PHASE_THIRD),
      .PHASE_QUARTER(PHASE_QUARTER),
      .HALF_THIRD(HALF_THIRD),
      .HALF_QUARTER(HALF_QUARTER),
      .QUARTER_DUTY(QUARTER_DUTY),
      .HALF_FRAME(HALF_FRAME)
   )
   u_frame
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .planeIdx(planeIdx),
      .phaseTick(phaseTick)
   );

   // Backplane select, fourth plane mirrors first at third duty
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         backplaneLine <= 4'h0;
      else if (!displayOn)
         backplaneLine <= 4'h0; // [R18]
      else
      begin
         backplaneLine <= 4'h1 << planeIdx; // [R15]
         if (!QUARTER_DUTY && planeIdx == 2'h0)
            backplaneLine <= 4'h9; // [R16]
      end
   end

   // One column flop per nibble, bit picked by plane
   generate
      for (genvar c = 0; c < NUM_COLS; c++)
      begin : g_col
         always_ff @(posedge sys_clk)
         begin
            if (!rst_n)
               column_reg[c] <= 1'b0;
            else
               column_reg[c] <= displayOn && ram_reg[c][planeIdx]; // [R15] [R16] [R18]
         end
      end
   endgenerate
   assign displayColumnLine = column_reg[DEDICATED_COLS-1:0];

   // Port pins: columns when selected, plain I/O otherwise
   generate
      for (genvar b = 0; b < 4; b++)
      begin : g_port
         always_ff @(posedge sys_clk)
         begin
            if (!rst_n)
            begin
               thirdIoPort.data[b] <= 1'b0;
               thirdIoPort.oe[b] <= 1'b0;
               fourthIoPort.data[b] <= 1'b0;
               fourthIoPort.oe[b] <= 1'b0;
            end
            else
            begin
               if (segExt_reg[SEGX_THIRD_IO_PORT_BIT])
               begin
                  thirdIoPort.data[b] <= column_reg[THIRD_IO_PORT_FIRST_COL+b]; // [R1] [R19]
                  thirdIoPort.oe[b] <= 1'b1;
               end
               else
               begin
                  thirdIoPort.data[b] <= thirdIoPortIo.data[b]; // [R1] [R19]
                  thirdIoPort.oe[b] <= thirdIoPortIo.oe[b];
               end
               if (segExt_reg[SEGX_FOURTH_IO_PORT_BIT])
               begin
                  fourthIoPort.data[b] <= column_reg[FOURTH_IO_PORT_FIRST_COL+b]; // [R2] [R19]
                  fourthIoPort.oe[b] <= 1'b1;
               end
               else
               begin
                  fourthIoPort.data[b] <= fourthIoPortIo.data[b]; // [R2] [R19]
                  fourthIoPort.oe[b] <= fourthIoPortIo.oe[b];
               end
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_third_io_port_select: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
      segExt_reg[SEGX_THIRD_IO_PORT_BIT] |=> thirdIoPort.oe == 4'hf
         && thirdIoPort.data == $past(column_reg[THIRD_IO_PORT_FIRST_COL+3:THIRD_IO_PORT_FIRST_COL]))
      else $error("third port not carrying columns");
   a_fourth_io_port_io: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
      !segExt_reg[SEGX_FOURTH_IO_PORT_BIT] |=> fourthIoPort.oe == $past(fourthIoPortIo.oe)
         && fourthIoPort.data == $past(fourthIoPortIo.data))
      else $error("fourth port not passing I/O data");
   a_pullup_follow: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
      wrPend_reg && wrIdx_reg == IDX_SEG_EXT ##2 1 |-> portPullupEnable == $past(hwdata[3], 2))
      else $error("pull-up enable does not follow written bit");
   a_stop_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
      stopExec |=> !pumpOn && !displayOn && shutdown_reg)
      else $error("stop did not power down");
   a_pad_shut: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R8]
      padActive && !SOLAR_SUPPLY && !watchdogResetEvent && !stopExec
         |=> shutdown_reg && !displayOn && pumpOn == $past(pumpOn))
      else $error("pad reset handling wrong");
   a_pump_cause: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
      $rose(pumpOn) |-> $past(writeClear))
      else $error("pump turned on without a clear write");
   a_blank_only: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R10]
      writeSet && !SOLAR_SUPPLY && pumpOn && !watchdogResetEvent && !stopExec
         |=> pumpOn && !displayOn)
      else $error("setting shutdown changed the pump");
   a_por_off: assert property (@(posedge sys_clk) // [R11]
      $rose(rst_n) |-> shutdown_reg && !pumpOn && !displayOn)
      else $error("not all off after power-on");
   a_pump_first: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R12]
      $rose(displayOn) |-> $past(pumpOn) && !shutdown_reg)
      else $error("display on before pump");
   a_solar_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R13]
      writeSet && SOLAR_SUPPLY |=> !pumpOn && !displayOn)
      else $error("solar shutdown left power on");
   a_solar_pad: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R14]
      padActive && SOLAR_SUPPLY && !watchdogResetEvent && !stopExec
         |=> $stable(pwr_reg) && $stable(shutdown_reg))
      else $error("pad reset changed solar power state");
   a_wdog_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R17]
      watchdogResetEvent |=> pwr_reg == PWR_OFF && shutdown_reg)
      else $error("watchdog did not power down");
   a_dark_lines: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R18]
      !displayOn |=> backplaneLine == 4'h0 && column_reg == '0)
      else $error("lines driven while display off");

   c_power_up: cover property (@(posedge sys_clk) disable iff (!rst_n)
      writeClear ##1 pumpOn ##1 displayOn);
   c_stop_down: cover property (@(posedge sys_clk) disable iff (!rst_n)
      displayOn ##1 stopExec ##1 !pumpOn);
   c_third_io_port_seg: cover property (@(posedge sys_clk) disable iff (!rst_n)
      segExt_reg[SEGX_THIRD_IO_PORT_BIT] && displayOn && thirdIoPort.data != 4'h0);

endmodule // lps_top

// ---- hw/lps_pkg.sv ----
package lps_pkg;
   // ---------------------------------------------------------------
   // Clock and frame timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int FRAME_HZ_THIRD = 43;
   localparam int FRAME_HZ_QUARTER = 32;
   localparam int HALF_HZ_THIRD = 21;
   localparam int HALF_HZ_QUARTER = 16;
   localparam int PLANES_THIRD = 3;
   localparam int PLANES_QUARTER = 4;
   // Cycles per backplane phase, rounded down
   localparam int PHASE_CYC_THIRD = CLK_HZ / (FRAME_HZ_THIRD * PLANES_THIRD);
   localparam int PHASE_CYC_QUARTER = CLK_HZ / (FRAME_HZ_QUARTER * PLANES_QUARTER);
   localparam int HALF_CYC_THIRD = CLK_HZ / (HALF_HZ_THIRD * PLANES_THIRD);
   localparam int HALF_CYC_QUARTER = CLK_HZ / (HALF_HZ_QUARTER * PLANES_QUARTER);
   localparam int PHASE_CNT_W = 20;

   // ---------------------------------------------------------------
   // Register map (word index, byte address = index * 4)
   // ---------------------------------------------------------------
   localparam logic [11:0] IDX_DISP_CTRL = 12'h013;
   localparam logic [11:0] IDX_SEG_EXT = 12'h015;
   localparam logic [11:0] IDX_RAM_FIRST = 12'h300;
   localparam logic [11:0] IDX_RAM_LAST = 12'h321;
   localparam int NUM_COLS = 34;
   localparam int NUM_PLANES = 4;
   localparam int DEDICATED_COLS = 26;
   localparam int THIRD_IO_PORT_FIRST_COL = 26;
   localparam int FOURTH_IO_PORT_FIRST_COL = 30;

   // Field positions
   localparam int CTRL_HEAVY_BIT = 1;
   localparam int CTRL_SHUT_BIT = 2;
   localparam int SEGX_THIRD_IO_PORT_BIT = 1;
   localparam int SEGX_FOURTH_IO_PORT_BIT = 2;
   localparam int SEGX_PULL_BIT = 3;

   // Reset values
   localparam logic [3:0] SEGX_RESET = 4'h0;
   localparam logic HEAVY_RESET = 1'b0;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0]
   {
      PWR_OFF = 2'b00,
      PWR_PUMP = 2'b01,
      PWR_ON = 2'b11
   } lps_power_t;

   typedef struct packed
   {
      logic [3:0] data;
      logic [3:0] oe;
   } lps_port_t;
endpackage

// ---- hw/lps_frame_gen.sv ----
`timescale 1ns/1ps
module lps_frame_gen
#(
   parameter int PHASE_THIRD = lps_pkg::PHASE_CYC_THIRD,
   parameter int PHASE_QUARTER = lps_pkg::PHASE_CYC_QUARTER,
   parameter int HALF_THIRD = lps_pkg::HALF_CYC_THIRD,
   parameter int HALF_QUARTER = lps_pkg::HALF_CYC_QUARTER,
   parameter bit QUARTER_DUTY = 1'b1,
   parameter bit HALF_FRAME = 1'b0
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   output logic [1:0] planeIdx,
   output logic phaseTick
);
   import lps_pkg::*;

   // ---------------------------------------------------------------
   // Phase length chosen by duty and frame mode
   // ---------------------------------------------------------------
   localparam int LIMIT = HALF_FRAME ? (QUARTER_DUTY ? HALF_QUARTER : HALF_THIRD)
                                     : (QUARTER_DUTY ? PHASE_QUARTER : PHASE_THIRD);
   localparam logic [PHASE_CNT_W-1:0] LAST_CNT = PHASE_CNT_W'(LIMIT - 1);
   localparam logic [1:0] LAST_PLANE = QUARTER_DUTY ? 2'h3 : 2'h2;

   logic [PHASE_CNT_W-1:0] cnt_reg;

   // Phase divider, one enable pulse per backplane phase
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         cnt_reg <= '0;
         phaseTick <= 1'b0;
      end
      else if (cnt_reg == LAST_CNT)
      begin
         cnt_reg <= '0; // [R4] [R5]
         phaseTick <= 1'b1;
      end
      else
      begin
         cnt_reg <= cnt_reg + 1'b1;
         phaseTick <= 1'b0;
      end
   end

   // Backplane index walks 0..LAST_PLANE
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         planeIdx <= 2'h0;
      else if (phaseTick)
         planeIdx <= (planeIdx == LAST_PLANE) ? 2'h0 : planeIdx + 2'h1; // [R15] [R16]
   end

   a_phase_bound: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R4]
      cnt_reg <= LAST_CNT && planeIdx <= LAST_PLANE)
      else $error("phase counter or plane index out of range");

endmodule // lps_frame_gen

// ---- sim/lps_glass_panel.sv ----
`timescale 1ns/1ps
module lps_glass_panel
(
   input wire logic sys_clk,
   input wire logic [lps_pkg::DEDICATED_COLS-1:0] displayColumnLine,
   input wire logic [lps_pkg::NUM_PLANES-1:0] backplaneLine,
   input wire lps_pkg::lps_port_t thirdIoPort,
   input wire lps_pkg::lps_port_t fourthIoPort,
   output logic [lps_pkg::NUM_PLANES-1:0][lps_pkg::NUM_COLS-1:0] frame,
   output logic [15:0] phaseLen
);
   import lps_pkg::*;
   // ---------------------------------------------------------------
   // Glass segment capture
   // ---------------------------------------------------------------
   logic [NUM_COLS-1:0] colNow;
   logic [NUM_PLANES-1:0] lastPlane = '0;
   logic [15:0] runCnt = 16'h0;

   // Port pins light a segment only while driven
   assign colNow = {fourthIoPort.data & fourthIoPort.oe, thirdIoPort.data & thirdIoPort.oe,
      displayColumnLine};

   // Lowest lit backplane names the plane; last cycle of a phase wins
   always_ff @(posedge sys_clk)
   begin
      for (int p = 0; p < NUM_PLANES; p++)
      begin
         if (backplaneLine[p] && (backplaneLine & ((4'h1 << p) - 4'h1)) == 4'h0)
         begin
            frame[p] <= colNow;
         end
      end
   end

   // Length of the last complete backplane phase
   always_ff @(posedge sys_clk)
   begin
      lastPlane <= backplaneLine;
      if (backplaneLine != lastPlane)
      begin
         phaseLen <= runCnt;
         runCnt <= 16'h1;
      end
      else
      begin
         runCnt <= runCnt + 16'h1;
      end
   end
endmodule // lps_glass_panel

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import lps_pkg::*;
   // ---------------------------------------------------------------
   // Bench signals
   // ---------------------------------------------------------------
   localparam int PH_Q = 8;
   localparam int PH_T = 6;
   localparam int HF_T = 12;
   localparam int HF_Q = 10;
   logic sys_clk, rst_n, hsel, hwrite, hready, padReset_n, stopExec, watchdogResetEvent;
   logic [31:0] haddr, hwdata, rdA, rdB, hrdataA, hrdataB;
   logic [1:0] htrans;
   logic [2:0] hsize;
   lps_port_t ioC, ioD, pinCA, pinDA, pinCB, pinDB;
   logic [25:0] colA, colB;
   logic [3:0] bpA, bpB;
   logic pumpA, pumpB, dispA, dispB, pullA, heavyA, respA, respB;
   logic [3:0][33:0] frmA, frmB;
   logic [15:0] lenA, lenB;
   int nFail, numChecks;

   // Plain supply, quarter duty, normal frame; it alone answers the bus
   lps_top #(.SOLAR_SUPPLY(1'b0), .QUARTER_DUTY(1'b1), .HALF_FRAME(1'b0), .PHASE_THIRD(PH_T),
      .PHASE_QUARTER(PH_Q), .HALF_THIRD(HF_T), .HALF_QUARTER(HF_Q)) lps_top_i (
      .sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hreadyout(hready), .hresp(respA), .hrdata(hrdataA), .padReset_n, .stopExec,
      .watchdogResetEvent, .thirdIoPortIo(ioC), .fourthIoPortIo(ioD), .thirdIoPort(pinCA),
      .fourthIoPort(pinDA), .displayColumnLine(colA), .backplaneLine(bpA), .pumpOn(pumpA),
      .displayOn(dispA), .portPullupEnable(pullA), .heavyLoadSelect(heavyA));
   // Solar supply, third duty, half frame; shares every input
   lps_top #(.SOLAR_SUPPLY(1'b1), .QUARTER_DUTY(1'b0), .HALF_FRAME(1'b1), .PHASE_THIRD(PH_T),
      .PHASE_QUARTER(PH_Q), .HALF_THIRD(HF_T), .HALF_QUARTER(HF_Q)) lps_top_s_i (
      .sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hreadyout(), .hresp(respB), .hrdata(hrdataB), .padReset_n, .stopExec,
      .watchdogResetEvent, .thirdIoPortIo(ioC), .fourthIoPortIo(ioD), .thirdIoPort(pinCB),
      .fourthIoPort(pinDB), .displayColumnLine(colB), .backplaneLine(bpB), .pumpOn(pumpB),
      .displayOn(dispB), .portPullupEnable(), .heavyLoadSelect());
   // Glass panels on both builds
   lps_glass_panel lps_glass_panel_i (.sys_clk, .displayColumnLine(colA), .backplaneLine(bpA),
      .thirdIoPort(pinCA), .fourthIoPort(pinDA), .frame(frmA), .phaseLen(lenA));
   lps_glass_panel lps_glass_panel_s_i (.sys_clk, .displayColumnLine(colB), .backplaneLine(bpB),
      .thirdIoPort(pinCB), .fourthIoPort(pinDB), .frame(frmB), .phaseLen(lenB));

   // 25 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      numChecks++;
      if (seen !== exp)
      begin
         nFail++;
         $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask

   // One single AHB transfer, read data from both builds
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'b010;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      rdA = hrdataA;
      rdB = hrdataB;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   function automatic logic [3:0] nib(input int c);
      return 4'(c * 5 + 3);
   endfunction

   // Clear shutdown; pump comes up before the display
   task automatic turnOn(input logic [31:0] v, input bit first);
      bus(32'h4c, 1'b1, v);
      settle(0);
      check({pumpA, pumpB}, 2'b11);
      if (first)
      begin
         check({dispA, dispB}, 2'b00);
      end
      settle(1);
      check({dispA, dispB}, 2'b11);
   endtask

   // Stop or watchdog pulse of one cycle
   task automatic pulse(input bit wd);
      @(posedge sys_clk);
      if (wd)
      begin
         watchdogResetEvent <= 1'b1;
      end
      else
      begin
         stopExec <= 1'b1;
      end
      @(posedge sys_clk);
      watchdogResetEvent <= 1'b0;
      stopExec <= 1'b0;
      settle(2);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic tReset;
      bus(32'h4c, 1'b0, 32'h0);
      check({rdA, rdB}, {32'h4, 32'h4});
      bus(32'h54, 1'b0, 32'h0);
      check(rdA, 32'h0);
      check({pumpA, dispA, pumpB, dispB, colA, bpA}, 34'h0);
      bus(32'h50, 1'b1, 32'hf);
      bus(32'h50, 1'b0, 32'h0);
      check(rdA, 32'h0);
      $display("test reset done");
   endtask

   task automatic tMap;
      logic [33:0] expv;
      logic [3:0] v;
      for (int c = 0; c < 34; c++)
      begin
         bus(32'hc00 + 32'(4 * c), 1'b1, 32'(nib(c)));
      end
      bus(32'h54, 1'b1, 32'h6);
      turnOn(32'h0, 1'b1);
      settle(80);
      for (int p = 0; p < 4; p++)
      begin
         for (int c = 0; c < 34; c++)
         begin
            v = nib(c);
            expv[c] = v[p];
         end
         check(frmA[p], expv);
         if (p < 3)
         begin
            check(frmB[p], expv);
         end
      end
      check({lenA, lenB}, {16'(PH_Q), 16'(HF_T)});
      $display("test map done");
   endtask

   task automatic tPorts;
      bus(32'h54, 1'b1, 32'h8);
      settle(2);
      check({pullA, pinCA, pinDA}, {1'b1, ioC, ioD});
      @(posedge sys_clk);
      ioC <= '{data: 4'h3, oe: 4'h9};
      settle(1);
      check(pinCA, 8'h39);
      bus(32'h54, 1'b0, 32'h0);
      check(rdA, 32'h8);
      $display("test ports done");
   endtask

   task automatic tSet;
      bus(32'h4c, 1'b1, 32'h7);
      settle(2);
      check({pumpA, dispA, pumpB, dispB}, 4'b1000);
      check({colA, bpA, colB, bpB, heavyA}, 61'h1);
      bus(32'h4c, 1'b0, 32'h0);
      check({rdA, rdB}, {32'h6, 32'h6});
      turnOn(32'h2, 1'b0);
      $display("test set done");
   endtask

   task automatic tPad;
      @(posedge sys_clk);
      padReset_n <= 1'b0;
      settle(5);
      check({pumpA, dispA, pumpB, dispB}, 4'b1011);
      @(posedge sys_clk);
      padReset_n <= 1'b1;
      settle(4);
      bus(32'h4c, 1'b0, 32'h0);
      check({rdA[2], rdB[2]}, 2'b10);
      turnOn(32'h2, 1'b0);
      $display("test pad done");
   endtask

   // Power-on reset in mid-run, with the display lit
   task automatic tPor;
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      settle(1);
      check({pumpA, dispA, pumpB, dispB, respA, respB}, 6'h0);
      bus(32'h4c, 1'b0, 32'h0);
      check({rdA[2], rdB[2]}, 2'b11);
      turnOn(32'h0, 1'b1);
      $display("test power-on done");
   endtask

   task automatic tOff(input bit wd);
      pulse(wd);
      check({pumpA, dispA, pumpB, dispB, colA, bpA}, 34'h0);
      bus(32'h4c, 1'b0, 32'h0);
      check({rdA[2], rdB[2]}, 2'b11);
      turnOn(32'h0, 1'b1);
      $display("test off done");
   endtask

   task automatic summarize;
      $display("checks %0d, mismatches %0d", numChecks, nFail);
      if (nFail == 0 && numChecks > 0)
      begin
         $display("All tests passed");
      end
      else
      begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      padReset_n = 1'b1;
      stopExec = 1'b0;
      watchdogResetEvent = 1'b0;
      ioC = '{data: 4'h5, oe: 4'hc};
      ioD = '{data: 4'ha, oe: 4'h3};
      nFail = 0;
      numChecks = 0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      tReset;
      tMap;
      tPorts;
      tSet;
      tPad;
      tPor;
      tOff(1'b0);
      tOff(1'b1);
      summarize;
   end

   // Hang guard, run needs well under 2000 cycles
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      nFail++;
      $display("wrong value at %0t: run did not finish", $time);
      summarize;
   end
endmodule // tb_top
